/* File: hw/ssr_pkg.sv */
// status reporting package: bit positions, widths, error queue sizing
// assumes a single 20 MHz system clock domain
package ssr_pkg;
    // ----------------------------------------------------------------
    // status byte layout
    // ----------------------------------------------------------------
    localparam int QUES_BIT    = 3;
    localparam int MAV_BIT     = 4;
    localparam int STDEV_BIT   = 5;
    localparam int RQS_BIT     = 6;
    localparam logic [7:0] STB_UNUSED_MASK = 8'h87;
    // ----------------------------------------------------------------
    // standard event bits
    // ----------------------------------------------------------------
    localparam int ESR_OPC_BIT   = 0;
    localparam int ESR_QUERY_BIT = 2;
    localparam int ESR_DEV_BIT   = 3;
    localparam int ESR_EXEC_BIT  = 4;
    localparam int ESR_CMD_BIT   = 5;
    localparam int ESR_PON_BIT   = 7;
    localparam logic [7:0] ESR_USED_MASK = 8'hbd;
    localparam int QUES_W = 16;
    // ----------------------------------------------------------------
    // error queue
    // ----------------------------------------------------------------
    localparam int ERRQ_DEPTH = 20;
    localparam int ERRQ_AW    = 5;
    localparam int ERR_CODE_W = 16;
    localparam int ERR_CHARS  = 80;
    localparam logic [ERRQ_AW-1:0] ERRQ_LAST = 5'h13;
    localparam logic [ERRQ_AW:0]   ERRQ_FULL = 6'h14;
    localparam logic [ERR_CODE_W-1:0] ERR_NONE = 16'h0000;
    localparam logic [ERR_CODE_W-1:0] ERR_OVERFLOW = 16'hfebe;
    typedef enum logic [1:0] {
        SSR_ANS_IDLE = 2'b00,
        SSR_ANS_BUSY = 2'b01
    } ssr_ans_e;
endpackage : ssr_pkg

/* File: hw/ssr_event_reg.sv */
// one latched event register with enable mask and summary bit
// assumes controls come from logic on the same clock
`timescale 1ns/1ps
module ssr_event_reg #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clkEn,
    // events and clears
    input  wire logic [W-1:0] evSet,
    input  wire logic         evClear,
    // enable mask
    input  wire logic         maskWr,
    input  wire logic [W-1:0] maskData,
    input  wire logic         maskClr,
    input  wire logic         maskPonClr,
    // state
    output logic      [W-1:0] events,
    output logic      [W-1:0] mask,
    output logic              summary
);
    logic [W-1:0] events_r;
    logic [W-1:0] mask_r;

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            events_r <= '0;
        end else if (clkEn) begin
            events_r <= (evClear ? '0 : events_r) | evSet;
        end
    end

    // masks survive reset unless power-on clear setting asks otherwise
    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            if (maskPonClr || maskClr) begin
                mask_r <= '0;
            end else if (maskWr) begin
                mask_r <= maskData;
            end
        end
    end

    assign events  = events_r;
    assign mask    = mask_r;
    assign summary = |(events_r & mask_r);
endmodule : ssr_event_reg

/* File: hw/ssr_status_srq.sv */
// status reporting core: event registers, status byte, service request,
// message-available tracking and error queue
// assumes the command parser gives one-cycle strobes on sys_clk; the bus
// serial-poll input arrives from a pin and is synchronised
`timescale 1ns/1ps
module ssr_status_srq (
    // clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    input  wire logic                            clkEn,
    // persisted power-on-clear setting and power-on indication
    input  wire logic                            pwrOnClrSetting,
    input  wire logic                            pwrOnEvent,
    // command strobes from the parser
    input  wire logic                            clearStatusCmd,
    input  wire logic                            statusPresetCmd,
    input  wire logic                            opcDone,
    input  wire logic                            esrQuery,
    input  wire logic                            quesQuery,
    input  wire logic                            stbQuery,
    input  wire logic                            eseWrite,
    input  wire logic                            quesEnWrite,
    input  wire logic                            sreWrite,
    input  wire logic [15:0]                     wrData,
    // error reports
    input  wire logic                            errQuery,
    input  wire logic                            errCmd,
    input  wire logic                            errExec,
    input  wire logic                            errDevice,
    input  wire logic                            overload,
    input  wire logic [ssr_pkg::QUES_W-1:0]      quesSet,
    input  wire logic [ssr_pkg::ERR_CODE_W-1:0]  errCode,
    input  wire logic                            errPop,
    // output buffer occupancy
    input  wire logic                            outBufNotEmpty,
    // bus side pins
    input  wire logic                            serialPollPin,
    // answers
    output logic      [7:0]                      status_summary_byte,
    output logic      [7:0]                      esrValue,
    output logic      [7:0]                      eseValue,
    output logic      [ssr_pkg::QUES_W-1:0]      quesValue,
    output logic      [ssr_pkg::QUES_W-1:0]      quesEnValue,
    output logic      [7:0]                      sreValue,
    output logic      [ssr_pkg::ERR_CODE_W-1:0]  errHead,
    output logic      [ssr_pkg::ERRQ_AW:0]       errCount,
    output logic                                 answerValid,
    output logic                                 srqOut,
    output logic                                 srqOutEn
);
    import ssr_pkg::*;
    // ----------------------------------------------------------------
    // synchronisers and power-on capture
    // ----------------------------------------------------------------
    logic spSync1_r;
    logic spSync2_r;
    logic spPrev_r;
    logic pocSync1_r;
    logic pocSync2_r;
    logic ponPending_r;
    logic ponMaskClr;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spSync1_r  <= 1'b0;
            spSync2_r  <= 1'b0;
            spPrev_r   <= 1'b0;
        end else if (clkEn) begin
            spSync1_r  <= serialPollPin;
            spSync2_r  <= spSync1_r;
            spPrev_r   <= spSync2_r;
        end
    end

    // the setting flops keep sampling through reset so the value is settled at release
    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            pocSync1_r <= pwrOnClrSetting;
            pocSync2_r <= pocSync1_r;
        end
    end

    // first enabled cycle after release; the setting is applied in the cycle after, not at reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ponPending_r <= 1'b1;
        end else if (clkEn) begin
            ponPending_r <= 1'b0;
        end
    end
    // two-stage setting is only valid after two enabled edges; keep power-on
    // window long enough by also using a delayed copy
    logic ponPending2_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ponPending2_r <= 1'b1;
        end else if (clkEn) begin
            ponPending2_r <= ponPending_r;
        end
    end
    assign ponMaskClr = ponPending2_r && !ponPending_r && pocSync2_r;

    logic serialPoll;
    assign serialPoll = spSync2_r && !spPrev_r;

    // ----------------------------------------------------------------
    // event registers
    // ----------------------------------------------------------------
    logic [7:0]             esrSet;
    logic [7:0]             esrEv;
    logic [7:0]             eseMask;
    logic                   esrSum;
    logic [QUES_W-1:0]      quesEv;
    logic [QUES_W-1:0]      quesMask;
    logic                   quesSum;

    always_comb begin
        esrSet = 8'h00;
        esrSet[ESR_OPC_BIT]   = opcDone;
        esrSet[ESR_QUERY_BIT] = errQuery;
        esrSet[ESR_DEV_BIT]   = errDevice | overload;
        esrSet[ESR_EXEC_BIT]  = errExec;
        esrSet[ESR_CMD_BIT]   = errCmd;
        esrSet[ESR_PON_BIT]   = pwrOnEvent | ponPending_r;
        esrSet = esrSet & ESR_USED_MASK;
    end

    // no device-clear or reset-command input reaches these registers
    ssr_event_reg #(.W(8)) stdEvent (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clkEn      (clkEn),
        .evSet      (esrSet),
        .evClear    (clearStatusCmd | esrQuery),
        .maskWr     (eseWrite),
        .maskData   (wrData[7:0]),
        .maskClr    (1'b0),
        .maskPonClr (ponMaskClr),
        .events     (esrEv),
        .mask       (eseMask),
        .summary    (esrSum)
    );

    ssr_event_reg #(.W(QUES_W)) quesEvent (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clkEn      (clkEn),
        .evSet      (quesSet),
        .evClear    (clearStatusCmd | quesQuery),
        .maskWr     (quesEnWrite),
        .maskData   (wrData),
        .maskClr    (statusPresetCmd),
        .maskPonClr (1'b0),
        .events     (quesEv),
        .mask       (quesMask),
        .summary    (quesSum)
    );

    // ----------------------------------------------------------------
    // service request enable and request bit
    // ----------------------------------------------------------------
    logic [7:0] sre_r;
    logic       rqs_r;
    logic       rqs_nxt;
    logic [7:0] stbBase;
    logic [7:0] stbLeft;
    logic       rqsCause;

    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            if (ponMaskClr) begin
                sre_r <= 8'h00;
            end else if (sreWrite) begin
                sre_r <= wrData[7:0] & ~STB_UNUSED_MASK;
            end
        end
    end

    always_comb begin
        stbBase = 8'h00;
        stbBase[QUES_BIT]  = quesSum;
        stbBase[MAV_BIT]   = outBufNotEmpty;
        stbBase[STDEV_BIT] = esrSum;
        // a queried register's summary no longer counts as a cause this cycle
        stbLeft = stbBase;
        if (esrQuery) begin
            stbLeft[STDEV_BIT] = 1'b0;
        end
        if (quesQuery) begin
            stbLeft[QUES_BIT] = 1'b0;
        end
        rqsCause = |(stbLeft & sre_r & ~STB_UNUSED_MASK);
    end

    // request clears only by poll or by the query that removes its cause
    always_comb begin
        rqs_nxt = rqs_r;
        if (serialPoll || ((esrQuery || quesQuery) && !rqsCause)) begin
            rqs_nxt = 1'b0;
        end
        if (rqsCause && !rqs_r && !serialPoll) begin
            rqs_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rqs_r <= 1'b0;
        end else if (clkEn) begin
            rqs_r <= rqs_nxt;
        end
    end

    // ----------------------------------------------------------------
    // error queue
    // ----------------------------------------------------------------
    logic [ERR_CODE_W-1:0] errMem_r [ERRQ_DEPTH];
    logic [ERRQ_AW-1:0]    wrPtr_r;
    logic [ERRQ_AW-1:0]    rdPtr_r;
    logic [ERRQ_AW:0]      cnt_r;
    logic                  errPush;
    logic                  doPop;
    logic                  doPush;

    // overload sets the device-error bit but queues nothing
    assign errPush = errQuery | errCmd | errExec | errDevice;
    assign doPop   = errPop && (cnt_r != '0);
    assign doPush  = errPush && (cnt_r != ERRQ_FULL);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r   <= '0;
        end else if (clkEn) begin
            if (clearStatusCmd) begin
                // an error in the clearing cycle stays queued, as its event bit does
                wrPtr_r <= {4'h0, errPush};
                rdPtr_r <= '0;
                cnt_r   <= {5'h00, errPush};
            end else begin
                if (doPush) begin
                    wrPtr_r <= (wrPtr_r == ERRQ_LAST) ? '0 : wrPtr_r + 1'b1;
                end
                if (doPop) begin
                    rdPtr_r <= (rdPtr_r == ERRQ_LAST) ? '0 : rdPtr_r + 1'b1;
                end
                cnt_r <= cnt_r + {5'h00, doPush} - {5'h00, doPop};
            end
        end
    end

    // a full queue overwrites its newest slot with an overflow marker
    always_ff @(posedge sys_clk) begin
        if (clkEn && clearStatusCmd) begin
            errMem_r[0] <= errCode;
        end else if (clkEn) begin
            if (doPush) begin
                errMem_r[wrPtr_r] <= errCode;
            end else if (errPush) begin
                errMem_r[(wrPtr_r == '0) ? ERRQ_LAST : wrPtr_r - 1'b1] <= ERR_OVERFLOW;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered answers
    // ----------------------------------------------------------------
    ssr_ans_e ansState_r;
    ssr_ans_e ansState_nxt;
    logic     anyQuery;
    assign anyQuery = esrQuery | quesQuery | stbQuery | errPop;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_summary_byte <= 8'h00;
            esrValue            <= 8'h00;
            eseValue            <= 8'h00;
            quesValue           <= '0;
            quesEnValue         <= '0;
            sreValue            <= 8'h00;
            errHead             <= ERR_NONE;
            errCount            <= '0;
            srqOut              <= 1'b0;
            srqOutEn            <= 1'b0;
        end else if (clkEn) begin
            status_summary_byte <= (stbBase | {1'b0, rqs_r, 6'h00}) & ~STB_UNUSED_MASK;
            // query values are the events before this cycle's clear takes effect
            if (esrQuery) begin
                esrValue <= esrEv;
            end
            if (quesQuery) begin
                quesValue <= quesEv;
            end
            eseValue    <= eseMask;
            quesEnValue <= quesMask;
            sreValue    <= sre_r;
            errHead     <= (cnt_r == '0) ? ERR_NONE : errMem_r[rdPtr_r];
            errCount    <= cnt_r;
            // open-drain request line: drive low while requesting
            srqOut      <= 1'b0;
            srqOutEn    <= rqs_r;
        end
    end

    // answer flag comes from a flop so the parser never sees a decode glitch
    always_comb begin
        ansState_nxt = ansState_r;
        case (ansState_r)
            SSR_ANS_IDLE: begin
                if (anyQuery) begin
                    ansState_nxt = SSR_ANS_BUSY;
                end
            end
            default: begin
                ansState_nxt = anyQuery ? SSR_ANS_BUSY : SSR_ANS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ansState_r  <= SSR_ANS_IDLE;
            answerValid <= 1'b0;
        end else if (clkEn) begin
            ansState_r  <= ansState_nxt;
            answerValid <= (ansState_nxt == SSR_ANS_BUSY);
        end
    end
endmodule : ssr_status_srq

/* File: sim/ssr_status_srq_sva.sv */
// concurrent checks on the status core, seen from its top ports only
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module ssr_status_srq_sva
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    // command and event strobes
    input wire logic                  esrQuery,
    input wire logic                  quesQuery,
    input wire logic                  stbQuery,
    input wire logic                  errPop,
    input wire logic                  clearStatusCmd,
    input wire logic                  statusPresetCmd,
    input wire logic                  eseWrite,
    input wire logic                  sreWrite,
    input wire logic                  errQuery,
    input wire logic                  errCmd,
    input wire logic                  errExec,
    input wire logic                  errDevice,
    input wire logic                  overload,
    input wire logic                  opcDone,
    input wire logic                  pwrOnEvent,
    // levels and pins
    input wire logic                  outBufNotEmpty,
    input wire logic                  serialPollPin,
    // observed outputs
    input wire logic [7:0]            status_summary_byte,
    input wire logic [7:0]            eseValue,
    input wire logic [7:0]            sreValue,
    input wire logic [QUES_W-1:0]     quesEnValue,
    input wire logic [ERRQ_AW:0]      errCount,
    input wire logic                  srqOut,
    input wire logic                  srqOutEn,
    input wire logic                  answerValid
);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    // the request may only drop shortly after one of these causes
    logic [5:0] clrHist_r;
    wire        setAny = errQuery | errCmd | errExec | errDevice | overload | opcDone | pwrOnEvent;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) clrHist_r <= 6'h00;
        else clrHist_r <= {clrHist_r[4:0], serialPollPin | esrQuery | quesQuery | clearStatusCmd};
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_unused_zero: assert property ((status_summary_byte & STB_UNUSED_MASK) == 8'h00)
        else $error("unused status byte bits set");
    a_srq_follows: assert property (srqOutEn == status_summary_byte[RQS_BIT])
        else $error("bus request line differs from request bit");
    a_srq_pull_low: assert property (srqOut == 1'b0)
        else $error("request line driven high");
    a_mav_set: assert property (outBufNotEmpty [*4] |-> status_summary_byte[MAV_BIT])
        else $error("message bit low while buffer holds data");
    a_mav_clear: assert property (!outBufNotEmpty [*4] |-> !status_summary_byte[MAV_BIT])
        else $error("message bit high with empty buffer");
    a_rqs_cause: assert property ($rose(status_summary_byte[RQS_BIT])
        |-> |(status_summary_byte & sreValue & 8'h38))
        else $error("request rose without enabled cause");
    a_rqs_drop_why: assert property ($fell(status_summary_byte[RQS_BIT]) |-> |clrHist_r)
        else $error("request dropped without poll or query");
    a_esr_query_clr: assert property (esrQuery && !setAny
        |-> ##[1:3] !status_summary_byte[STDEV_BIT])
        else $error("event summary kept after query");
    a_mask_kept: assert property (clearStatusCmd && !eseWrite && !sreWrite
        |=> $stable(eseValue) && $stable(sreValue))
        else $error("clear status changed a mask");
    a_preset_zero: assert property (statusPresetCmd |-> ##[1:2] quesEnValue == '0)
        else $error("preset left questionable mask set");
    a_errq_bound: assert property (errCount <= ERRQ_FULL)
        else $error("error queue count above depth");
    a_answer_flag: assert property (esrQuery || quesQuery || stbQuery || errPop |=> answerValid)
        else $error("no answer flag after a query");
endmodule : ssr_status_srq_sva

bind ssr_status_srq ssr_status_srq_sva ssr_status_srq_sva_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .esrQuery(esrQuery), .quesQuery(quesQuery),
    .clearStatusCmd(clearStatusCmd), .statusPresetCmd(statusPresetCmd),
    .eseWrite(eseWrite), .sreWrite(sreWrite), .errQuery(errQuery), .errCmd(errCmd),
    .errExec(errExec), .errDevice(errDevice), .overload(overload), .opcDone(opcDone),
    .pwrOnEvent(pwrOnEvent), .outBufNotEmpty(outBufNotEmpty), .serialPollPin(serialPollPin),
    .status_summary_byte(status_summary_byte), .eseValue(eseValue), .sreValue(sreValue),
    .quesEnValue(quesEnValue), .errCount(errCount), .srqOut(srqOut), .srqOutEn(srqOutEn),
    .stbQuery(stbQuery), .errPop(errPop), .answerValid(answerValid));

/* File: sim/ssr_ctrl_model.sv */
// behavioural bus controller: answers the request line with a serial poll
// assumes the bench enables it only when polling is wanted
`timescale 1ns/1ps
module ssr_ctrl_model #(
    parameter int POLL_DLY = 5
) (
    // clock and control
    input  wire logic sys_clk,
    input  wire logic pollEn,
    // bus side
    input  wire logic srqOutEn,
    output logic      serialPollPin
);
    // ----------------------------------------------------------------
    // poll sequencer
    // ----------------------------------------------------------------
    // a slow reply is realistic: the controller needs time to notice the line
    initial serialPollPin = 1'b0;
    always begin
        @(posedge sys_clk);
        if (pollEn && srqOutEn) begin
            repeat (POLL_DLY) @(posedge sys_clk);
            serialPollPin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            serialPollPin <= 1'b0;
        end
    end
endmodule : ssr_ctrl_model

/* File: sim/status_reporting_srq_bench.sv */
// self-checking bench for the status core, with a polling controller model
// assumes strobes are taken on rising sys_clk while clkEn is high
`timescale 1ns/1ps
module status_reporting_srq_bench;
    import ssr_pkg::*;
    typedef struct {int idx; logic [7:0] expEsr; logic [5:0] expCnt;} ssr_row_s;
    logic        sys_clk, rst_n, pwrOnClrSetting, outBufNotEmpty, pollEn, serialPollPin;
    logic [15:0] cmdV, wrData, errCode, quesSet, quesValue, quesEnValue, errHead;
    logic [7:0]  stb, esrValue, eseValue, sreValue;
    logic [5:0]  errCount;
    logic        answerValid, srqOut, srqOutEn, seen;
    int          miscompares = 0;
    int          checks_done = 0;
    ssr_row_s    rows [7] = '{'{9, 8'h04, 6'h01}, '{12, 8'h08, 6'h01}, '{11, 8'h10, 6'h01},
                             '{10, 8'h20, 6'h01}, '{13, 8'h08, 6'h00}, '{2, 8'h01, 6'h00},
                             '{15, 8'h80, 6'h00}};
    ssr_status_srq ssr_status_srq_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .pwrOnClrSetting(pwrOnClrSetting),
        .pwrOnEvent(cmdV[15]), .clearStatusCmd(cmdV[0]), .statusPresetCmd(cmdV[1]),
        .opcDone(cmdV[2]), .esrQuery(cmdV[3]), .quesQuery(cmdV[4]), .stbQuery(cmdV[5]),
        .eseWrite(cmdV[6]), .quesEnWrite(cmdV[7]), .sreWrite(cmdV[8]), .wrData(wrData),
        .errQuery(cmdV[9]), .errCmd(cmdV[10]), .errExec(cmdV[11]), .errDevice(cmdV[12]),
        .overload(cmdV[13]), .quesSet(quesSet), .errCode(errCode), .errPop(cmdV[14]),
        .outBufNotEmpty(outBufNotEmpty), .serialPollPin(serialPollPin),
        .status_summary_byte(stb), .esrValue(esrValue), .eseValue(eseValue),
        .quesValue(quesValue), .quesEnValue(quesEnValue), .sreValue(sreValue),
        .errHead(errHead), .errCount(errCount), .answerValid(answerValid), .srqOut(srqOut),
        .srqOutEn(srqOutEn));
    ssr_ctrl_model ssr_ctrl_model_i (
        .sys_clk(sys_clk), .pollEn(pollEn), .srqOutEn(srqOutEn),
        .serialPollPin(serialPollPin));
    // ----------------------------------------------------------------
    // clock and tasks
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chkb
    // one-cycle strobe, then idle long enough for every registered answer
    task automatic strobe(input int idx, input logic [15:0] d);
        @(posedge sys_clk);
        cmdV[idx] <= 1'b1;
        wrData    <= d;
        errCode   <= d;
        @(posedge sys_clk);
        cmdV <= 16'h0000;
        repeat (3) @(posedge sys_clk);
    endtask : strobe
    task automatic do_reset(input logic pon);
        pwrOnClrSetting <= pon;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask : do_reset
    task automatic print_verdict;
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0; pwrOnClrSetting = 1'b1; cmdV = 16'h0000; wrData = 16'h0000;
        errCode = 16'h0000; quesSet = 16'h0000; outBufNotEmpty = 1'b0; pollEn = 1'b0;
        repeat (6) @(posedge sys_clk);
        chk({8'h00, stb}, 16'h0000);
        chkb(srqOutEn, 1'b0);
        rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk({8'h00, sreValue}, 16'h0000);
        chk({8'h00, eseValue}, 16'h0000);
        strobe(3, 16'h0000);
        chk({8'h00, esrValue}, 16'h0080);
        strobe(6, 16'h003c);
        strobe(8, 16'h0000);
        foreach (rows[i]) begin
            strobe(0, 16'h0000);
            strobe(rows[i].idx, 16'h0042);
            chk({8'h00, stb}, ((rows[i].expEsr & 8'h3c) != 8'h00) ? 16'h0020 : 16'h0000);
            strobe(3, 16'h0000);
            chk({8'h00, esrValue}, {8'h00, rows[i].expEsr});
            chk({10'h000, errCount}, {10'h000, rows[i].expCnt});
            chk({8'h00, stb}, 16'h0000);
        end
        chk({8'h00, eseValue}, 16'h003c);
        // questionable summary, query and preset
        strobe(7, 16'h0201);
        @(posedge sys_clk) quesSet <= 16'h0201;
        @(posedge sys_clk) quesSet <= 16'h0000;
        repeat (4) @(posedge sys_clk);
        chk({8'h00, stb}, 16'h0008);
        strobe(4, 16'h0000);
        chk(quesValue, 16'h0201);
        chk({8'h00, stb}, 16'h0000);
        @(posedge sys_clk) quesSet <= 16'h0001;
        @(posedge sys_clk) quesSet <= 16'h0000;
        strobe(1, 16'h0000);
        chk(quesEnValue, 16'h0000);
        chk({8'h00, stb}, 16'h0000);
        // message available follows the output buffer
        outBufNotEmpty <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk({8'h00, stb}, 16'h0010);
        outBufNotEmpty <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({8'h00, stb}, 16'h0000);
        // service request, status query, serial poll, event query
        strobe(6, 16'h0020);
        strobe(8, 16'h00ff);
        chk({8'h00, sreValue}, 16'h0078);
        strobe(0, 16'h0000);
        strobe(10, 16'h0077);
        chk({8'h00, stb}, 16'h0060);
        chkb(srqOutEn, 1'b1);
        strobe(5, 16'h0000);
        chk({8'h00, stb}, 16'h0060);
        seen = 1'b0;
        pollEn <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (stb[6] === 1'b0 && !seen) begin
                seen = 1'b1;
                chk({8'h00, stb}, 16'h0020);
            end
        end
        pollEn <= 1'b0;
        chkb(seen, 1'b1);
        repeat (20) @(posedge sys_clk);
        strobe(3, 16'h0000);
        chk({8'h00, stb}, 16'h0000);
        chk({8'h00, esrValue}, 16'h0020);
        // error queue overflow and oldest-first drain
        strobe(0, 16'h0000);
        for (int i = 0; i < 21; i++) begin
            @(posedge sys_clk);
            cmdV[11] <= 1'b1;
            errCode  <= 16'h0100 + 16'(i);
        end
        @(posedge sys_clk) cmdV <= 16'h0000;
        repeat (3) @(posedge sys_clk);
        chk({10'h000, errCount}, 16'h0014);
        for (int i = 0; i < 20; i++) begin
            chk(errHead, (i < 19) ? 16'h0100 + 16'(i) : ERR_OVERFLOW);
            strobe(14, 16'h0000);
        end
        strobe(14, 16'h0000);
        chk({10'h000, errCount}, 16'h0000);
        chk(errHead, ERR_NONE);
        // enable mask survives power-on only with the setting low
        do_reset(1'b0);
        chk({8'h00, sreValue}, 16'h0078);
        do_reset(1'b1);
        chk({8'h00, sreValue}, 16'h0000);
        print_verdict();
    end
endmodule : status_reporting_srq_bench
